// ==== hw/rfqirq_map.svh ====
// register offsets, field positions, reset values and sizes for the
// radio queue and event block; assumes an 8-bit special register space
// Functional notes
// - eight event flags, reset zero, write-zero clears
// - transmit done, also on acks if selected
// - one mask bit per flag, zero disables
// - data port writes push, reads pop
// - status bits come from receive queue only
// - flush strobes empty their queues
// - 128 bytes per queue
// - dma trigger on receive empty to nonempty
// - dma trigger on read with bytes remaining
// - frame delimiter received sets flag
// - delimiter status drops at end or filter fail
// - length byte first; nonempty until empty
// - readable receive byte count
// - threshold status when count exceeds level
// - filtering holds threshold low until pass
// - frame end raises threshold until one read
// - failed frame may be discarded; reader waits
// - several frames fit within 128 bytes
// - overflow: error irq, nonempty low, threshold high
// - overflow keeps stored bytes intact
// - after overflow no data until flush
// - flags update regardless of mask
// - flags set on rising source edges
// - underflow and overflow go to error irq
`ifndef RFQIRQ_MAP_SVH
`define RFQIRQ_MAP_SVH
`define RFQ_ADDR_MASK     8'h91
`define RFQ_ADDR_DATA     8'hd9
`define RFQ_ADDR_FLAGS    8'he9
`define RFQ_FLAGS_RESET   8'h00
`define RFQ_MASK_RESET    8'h00
`define RFQ_DATA_RESET    8'h00
`define RFQ_BIT_REG_ON    7
`define RFQ_BIT_TX_DONE   6
`define RFQ_BIT_THRESH    5
`define RFQ_BIT_DELIM     4
`define RFQ_BIT_CLEAR     3
`define RFQ_BIT_SP_WAIT   2
`define RFQ_BIT_SP_STOP   1
`define RFQ_BIT_SP_INT    0
`define RFQ_DEPTH         128
`define RFQ_PTR_W         7
`define RFQ_CNT_W         8
`endif

// ==== hw/rfqirq_pkg.sv ====
// types shared by the radio queue and event block
// assumes the map header for sizes
`include "rfqirq_map.svh"
package rfqirq_pkg;
  // register side request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rfqirq_sfr_t;
  // modem receive side events
  typedef struct packed {
    logic       push;
    logic [7:0] data;
    logic       delim_done;
    logic       frame_end;
    logic       addr_pass;
    logic       addr_fail;
  } rfqirq_rx_t;
  // radio event sources
  typedef struct packed {
    logic reg_on;
    logic tx_sent;
    logic ack_sent;
    logic chan_clear;
    logic sp_wait;
    logic sp_stop;
    logic sp_int;
    logic tx_underflow;
  } rfqirq_src_t;
  typedef enum logic [2:0] {
    RFQIRQ_IDLE  = 3'b001,
    RFQIRQ_FRAME = 3'b010,
    RFQIRQ_OVER  = 3'b100
  } rfqirq_rx_state_t;
endpackage

// ==== hw/rfqirq_top.sv ====
// radio receive/transmit queues, receive status and event flags
// assumes cpu register strobes and modem events on sys_clk
`timescale 1ns/100ps
`include "rfqirq_map.svh"
module rfqirq_top (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire rfqirq_pkg::rfqirq_sfr_t sfr,
  output logic [7:0]                 sfr_rdata,
  input  wire rfqirq_pkg::rfqirq_rx_t  rx,
  input  wire rfqirq_pkg::rfqirq_src_t src,
  input  wire logic                  tx_pop,
  output logic [7:0]                 tx_data,
  output logic                       tx_empty,
  input  wire logic                  transmit_flush_strobe,
  input  wire logic                  receive_flush_strobe,
  input  wire logic                  ack_source_select,
  input  wire logic [6:0]            receive_threshold_level,
  input  wire logic                  addr_filter_en,
  output logic                       receive_nonempty_status,
  output logic                       receive_threshold_status,
  output logic                       frame_delimiter_status,
  output logic [7:0]                 receive_byte_count,
  output logic                       radio_dma_trigger,
  output logic                       radio_interrupt,
  output logic                       radio_error_interrupt
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  function automatic logic [6:0] inc7(input logic [6:0] v);
    inc7 = v + 7'd1;
  endfunction

  // ------------------------------------------------------------
  // register strobes
  // ------------------------------------------------------------
  logic wr_data, rd_data, wr_mask, wr_flags;
  assign wr_data  = sfr.wr && sfr.addr == `RFQ_ADDR_DATA;
  assign rd_data  = sfr.rd && sfr.addr == `RFQ_ADDR_DATA;
  assign wr_mask  = sfr.wr && sfr.addr == `RFQ_ADDR_MASK;
  assign wr_flags = sfr.wr && sfr.addr == `RFQ_ADDR_FLAGS;

  // ------------------------------------------------------------
  // transmit queue
  // ------------------------------------------------------------
  logic [7:0] tx_mem [`RFQ_DEPTH];
  logic [6:0] tx_wp, tx_rp;
  logic [7:0] tx_cnt;
  logic       tx_push, tx_take;
  assign tx_push = wr_data && tx_cnt != 8'(`RFQ_DEPTH);
  assign tx_take = tx_pop && tx_cnt != 8'h00;
  always_ff @(posedge sys_clk) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= sfr.wdata;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp    <= 7'h00;
      tx_rp    <= 7'h00;
      tx_cnt   <= 8'h00;
      tx_data  <= 8'h00;
      tx_empty <= 1'b1;
    end else if (transmit_flush_strobe) begin
      tx_wp    <= 7'h00;
      tx_rp    <= 7'h00;
      tx_cnt   <= 8'h00;
      tx_empty <= 1'b1;
    end else begin
      if (tx_push) tx_wp <= inc7(tx_wp);
      if (tx_take) begin
        tx_rp   <= inc7(tx_rp);
        tx_data <= tx_mem[tx_rp];
      end
      tx_cnt   <= tx_cnt + 8'(tx_push) - 8'(tx_take);
      tx_empty <= (tx_cnt + 8'(tx_push) - 8'(tx_take)) == 8'h00;
    end
  end

  // ------------------------------------------------------------
  // receive queue
  // ------------------------------------------------------------
  logic [7:0] rx_mem [`RFQ_DEPTH];
  logic [6:0] rx_wp, rx_rp;
  logic [7:0] rx_cnt, next_rx_cnt;
  logic       rx_push, rx_take, overflow;
  logic       frame_ok, end_hold;
  rfqirq_pkg::rfqirq_rx_state_t st;
  assign overflow = rx.push && rx_cnt == 8'(`RFQ_DEPTH)
                    && st != rfqirq_pkg::RFQIRQ_OVER;
  assign rx_push  = rx.push && rx_cnt != 8'(`RFQ_DEPTH)
                    && st != rfqirq_pkg::RFQIRQ_OVER;
  assign rx_take  = rd_data && rx_cnt != 8'h00;
  assign next_rx_cnt = rx_cnt + 8'(rx_push) - 8'(rx_take);
  always_ff @(posedge sys_clk) begin
    if (rx_push) begin
      rx_mem[rx_wp] <= rx.data;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp  <= 7'h00;
      rx_rp  <= 7'h00;
      rx_cnt <= 8'h00;
    end else if (receive_flush_strobe) begin
      rx_wp  <= 7'h00;
      rx_rp  <= 7'h00;
      rx_cnt <= 8'h00;
    end else begin
      if (rx_push) rx_wp <= inc7(rx_wp);
      if (rx_take) rx_rp <= inc7(rx_rp);
      rx_cnt <= next_rx_cnt;
    end
  end

  // ------------------------------------------------------------
  // receive frame state
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st       <= rfqirq_pkg::RFQIRQ_IDLE;
      frame_ok <= 1'b0;
    end else if (receive_flush_strobe) begin
      st       <= rfqirq_pkg::RFQIRQ_IDLE;
      frame_ok <= 1'b0;
    end else begin
      unique case (st)
        rfqirq_pkg::RFQIRQ_IDLE: begin
          if (overflow) st <= rfqirq_pkg::RFQIRQ_OVER;
          else if (rx.delim_done) begin
            st       <= rfqirq_pkg::RFQIRQ_FRAME;
            frame_ok <= !addr_filter_en;
          end
        end
        rfqirq_pkg::RFQIRQ_FRAME: begin
          if (overflow) st <= rfqirq_pkg::RFQIRQ_OVER;
          else if (rx.addr_fail || rx.frame_end) begin
            st <= rfqirq_pkg::RFQIRQ_IDLE;
          end else if (rx.addr_pass) begin
            frame_ok <= 1'b1;
          end
        end
        rfqirq_pkg::RFQIRQ_OVER: begin
          st <= rfqirq_pkg::RFQIRQ_OVER;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // receive status
  // ------------------------------------------------------------
  logic thr_hit;
  assign thr_hit = next_rx_cnt > {1'b0, receive_threshold_level};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      end_hold <= 1'b0;
    end else if (receive_flush_strobe || rx_take) begin
      end_hold <= 1'b0;
    end else if (rx.frame_end && st == rfqirq_pkg::RFQIRQ_FRAME) begin
      end_hold <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_nonempty_status  <= 1'b0;
      receive_threshold_status <= 1'b0;
      frame_delimiter_status   <= 1'b0;
      receive_byte_count       <= 8'h00;
    end else begin
      receive_byte_count <= receive_flush_strobe ? 8'h00 : next_rx_cnt;
      if (receive_flush_strobe) begin
        receive_nonempty_status  <= 1'b0;
        receive_threshold_status <= 1'b0;
      end else if (overflow || st == rfqirq_pkg::RFQIRQ_OVER) begin
        receive_nonempty_status  <= 1'b0;
        receive_threshold_status <= 1'b1;
      end else begin
        receive_nonempty_status  <= next_rx_cnt != 8'h00;
        receive_threshold_status <= (thr_hit && (frame_ok
          || st != rfqirq_pkg::RFQIRQ_FRAME)) || (end_hold && !rx_take)
          || (rx.frame_end && st == rfqirq_pkg::RFQIRQ_FRAME);
      end
      if (rx.delim_done && st == rfqirq_pkg::RFQIRQ_IDLE) begin
        frame_delimiter_status <= 1'b1;
      end else if (st != rfqirq_pkg::RFQIRQ_FRAME || rx.frame_end
                   || rx.addr_fail || receive_flush_strobe) begin
        frame_delimiter_status <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // dma trigger
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      radio_dma_trigger <= 1'b0;
    end else begin
      radio_dma_trigger <= !receive_flush_strobe
        && ((rx_cnt == 8'h00 && rx_push)
        || (rx_take && next_rx_cnt != 8'h00));
    end
  end

  // ------------------------------------------------------------
  // event flags and mask
  // ------------------------------------------------------------
  logic [7:0] cond, cond_d, rise, flags, mask;
  always_comb begin
    cond = 8'h00;
    cond[`RFQ_BIT_REG_ON]  = src.reg_on;
    cond[`RFQ_BIT_TX_DONE] = src.tx_sent
                             || (src.ack_sent && ack_source_select);
    cond[`RFQ_BIT_THRESH]  = receive_threshold_status;
    cond[`RFQ_BIT_DELIM]   = frame_delimiter_status;
    cond[`RFQ_BIT_CLEAR]   = src.chan_clear;
    cond[`RFQ_BIT_SP_WAIT] = src.sp_wait;
    cond[`RFQ_BIT_SP_STOP] = src.sp_stop;
    cond[`RFQ_BIT_SP_INT]  = src.sp_int;
  end
  assign rise = cond & ~cond_d;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_d <= 8'h00;
      flags  <= `RFQ_FLAGS_RESET;
      mask   <= `RFQ_MASK_RESET;
    end else begin
      cond_d <= cond;
      // set wins over a same-cycle write of zero
      flags  <= (wr_flags ? (flags & sfr.wdata) : flags) | rise;
      if (wr_mask) mask <= sfr.wdata;
    end
  end

  // ------------------------------------------------------------
  // interrupts and read data
  // ------------------------------------------------------------
  logic [7:0] next_flags;
  assign next_flags = (wr_flags ? (flags & sfr.wdata) : flags) | rise;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      radio_interrupt       <= 1'b0;
      radio_error_interrupt <= 1'b0;
      sfr_rdata             <= `RFQ_DATA_RESET;
    end else begin
      radio_interrupt <= |(next_flags
                           & (wr_mask ? sfr.wdata : mask));
      radio_error_interrupt <= overflow || src.tx_underflow;
      if (sfr.rd) begin
        unique case (sfr.addr)
          `RFQ_ADDR_DATA:  sfr_rdata <= rx_take ? rx_mem[rx_rp] : 8'h00;
          `RFQ_ADDR_MASK:  sfr_rdata <= mask;
          `RFQ_ADDR_FLAGS: sfr_rdata <= flags;
          default:         sfr_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_flag_rise;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(frame_delimiter_status) |=> flags[`RFQ_BIT_DELIM];
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("delim flag");

  property p_mask_irq;
    @(posedge sys_clk) disable iff (!rst_n)
      (mask == 8'h00 && !wr_mask) |=> !radio_interrupt;
  endproperty
  a_mask_irq: assert property (p_mask_irq) else $error("masked irq");

  property p_irq_or;
    @(posedge sys_clk) disable iff (!rst_n)
      ##1 radio_interrupt == |(flags & mask);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq or");

  property p_dma_first;
    @(posedge sys_clk) disable iff (!rst_n)
      (rx_push && rx_cnt == 8'h00 && !receive_flush_strobe)
        |=> radio_dma_trigger;
  endproperty
  a_dma_first: assert property (p_dma_first) else $error("dma first");

  property p_dma_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (rx_take && rx_cnt > 8'h01 && !receive_flush_strobe)
        |=> radio_dma_trigger;
  endproperty
  a_dma_read: assert property (p_dma_read) else $error("dma read");

  property p_flush_rx;
    @(posedge sys_clk) disable iff (!rst_n)
      receive_flush_strobe |=> rx_cnt == 8'h00 && !receive_nonempty_status;
  endproperty
  a_flush_rx: assert property (p_flush_rx) else $error("rx flush");

  property p_over_block;
    @(posedge sys_clk) disable iff (!rst_n)
      (st == rfqirq_pkg::RFQIRQ_OVER && !receive_flush_strobe)
        |=> $stable(rx_wp);
  endproperty
  a_over_block: assert property (p_over_block) else $error("ovf write");

  property p_over_status;
    @(posedge sys_clk) disable iff (!rst_n)
      (overflow && !receive_flush_strobe) |=> radio_error_interrupt
        && !receive_nonempty_status && receive_threshold_status;
  endproperty
  a_over_status: assert property (p_over_status) else $error("ovf st");

  property p_count;
    @(posedge sys_clk) disable iff (!rst_n)
      ##1 receive_byte_count == rx_cnt;
  endproperty
  a_count: assert property (p_count) else $error("count");

endmodule

// ==== sim/rfqirq_cpu_model.sv ====
// cpu and dma side model: special register cycles, dma trigger count
// assumes inputs are sampled by the block on rising sys_clk edges
`timescale 1ns/100ps
module rfqirq_cpu_model (
  input  wire logic                   sys_clk,
  output rfqirq_pkg::rfqirq_sfr_t     sfr,
  input  wire logic [7:0]             sfr_rdata,
  input  wire logic                   radio_dma_trigger
);
  int dma_count = 0;
  initial sfr = '0;
  // ----------------------------------------
  // dma trigger counter
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (radio_dma_trigger === 1'b1)
      dma_count++;
  end
  // ----------------------------------------
  // register cycles, released lines inverted
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    sfr = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    sfr = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    @(negedge sys_clk);
    d = sfr_rdata;
  endtask
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the radio queue and event block
// assumes the cpu model file and the design files are compiled first
`timescale 1ns/100ps
module tb;
  logic                    sys_clk = 1'b0;
  logic                    rstn = 1'b0;
  rfqirq_pkg::rfqirq_sfr_t sfr;
  logic [7:0]              sfr_rdata;
  rfqirq_pkg::rfqirq_rx_t  rx = '0;
  rfqirq_pkg::rfqirq_src_t src = '0;
  logic                    tx_pop = 1'b0;
  logic [7:0]              tx_data;
  logic                    tx_empty;
  logic                    tx_fl = 1'b0;
  logic                    rx_fl = 1'b0;
  logic                    ack_sel = 1'b0;
  logic [6:0]              thr = 7'h03;
  logic                    filt = 1'b0;
  logic                    nonempty, thresh, delim, dma, irq, err;
  logic [7:0]              count, d;
  int                      n_fail = 0;
  int                      cmp_count = 0;
  int                      err_count = 0;
  int                      cyc = 0;
  always #20 sys_clk = ~sys_clk;
  rfqirq_top dut (.sys_clk(sys_clk), .rstn(rstn), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .rx(rx), .src(src), .tx_pop(tx_pop),
    .tx_data(tx_data), .tx_empty(tx_empty), .transmit_flush_strobe(tx_fl),
    .receive_flush_strobe(rx_fl), .ack_source_select(ack_sel),
    .receive_threshold_level(thr), .addr_filter_en(filt),
    .receive_nonempty_status(nonempty), .receive_threshold_status(thresh),
    .frame_delimiter_status(delim), .receive_byte_count(count),
    .radio_dma_trigger(dma), .radio_interrupt(irq),
    .radio_error_interrupt(err));
  rfqirq_cpu_model cpu (.sys_clk(sys_clk), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .radio_dma_trigger(dma));
  // ----------------------------------------
  // watchdog and error pulse count
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (err === 1'b1)
      err_count++;
    if (cyc == 6000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic rxp(input rfqirq_pkg::rfqirq_rx_t v);
    @(negedge sys_clk);
    rx = v;
    @(negedge sys_clk);
    rx = '0;
  endtask
  task automatic push(input logic [7:0] b);
    rxp('{push: 1'b1, data: b, default: 1'b0});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    cpu.rd(8'h91, d); chk(d, 8'h00);
    cpu.rd(8'he9, d); chk(d, 8'h00);
    cpu.rd(8'hd9, d); chk(d, 8'h00);
    cpu.rd(8'h42, d); chk(d, 8'h00);
    chk({tx_empty, nonempty, thresh, delim}, 8'h08);
    $display("test reset done");
  endtask
  task automatic t_tx();
    cpu.wr(8'hd9, 8'h5a);
    cpu.wr(8'hd9, 8'ha5);
    chk({7'h0, tx_empty}, 8'h00);
    chk({nonempty, thresh, count[5:0]}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(negedge sys_clk) tx_pop = 1'b1;
      @(negedge sys_clk) tx_pop = 1'b0;
      chk(tx_data, i == 0 ? 8'h5a : 8'ha5);
    end
    chk({7'h0, tx_empty}, 8'h01);
    cpu.wr(8'hd9, 8'h11);
    @(negedge sys_clk) tx_fl = 1'b1;
    @(negedge sys_clk) tx_fl = 1'b0;
    @(negedge sys_clk);
    chk({7'h0, tx_empty}, 8'h01);
    $display("test tx done");
  endtask
  task automatic t_rx();
    int dma0;
    dma0 = cpu.dma_count;
    rxp('{delim_done: 1'b1, default: 1'b0});
    @(negedge sys_clk);
    chk({7'h0, delim}, 8'h01);
    cpu.rd(8'he9, d); chk(d, 8'h10);
    for (int i = 0; i < 5; i++)
      push(i == 0 ? 8'h04 : 8'h20 + i[7:0]);
    @(negedge sys_clk);
    chk(count, 8'h05);
    chk({nonempty, thresh}, 8'h03);
    rxp('{frame_end: 1'b1, default: 1'b0});
    @(negedge sys_clk);
    chk({7'h0, delim}, 8'h00);
    cpu.rd(8'he9, d); chk(d, 8'h30);
    for (int i = 0; i < 5; i++) begin
      cpu.rd(8'hd9, d);
      chk(d, i == 0 ? 8'h04 : 8'h20 + i[7:0]);
    end
    chk({count[5:0], nonempty, thresh}, 8'h00);
    chk(8'(cpu.dma_count - dma0), 8'h05);
    cpu.wr(8'he9, 8'h00);
    $display("test rx done");
  endtask
  task automatic t_short();
    thr = 7'h10;
    rxp('{delim_done: 1'b1, default: 1'b0});
    push(8'h01);
    push(8'h77);
    rxp('{frame_end: 1'b1, default: 1'b0});
    @(negedge sys_clk);
    chk({7'h0, thresh}, 8'h01);
    cpu.rd(8'hd9, d); chk(d, 8'h01);
    chk({nonempty, thresh}, 8'h02);
    cpu.rd(8'hd9, d); chk(d, 8'h77);
    cpu.wr(8'he9, 8'h00);
    thr = 7'h03;
    $display("test short frame done");
  endtask
  task automatic t_over();
    int e0;
    e0 = err_count;
    for (int i = 0; i < 129; i++)
      push(i[7:0] + 8'h01);
    repeat (2) @(negedge sys_clk);
    chk(count, 8'h80);
    chk({nonempty, thresh}, 8'h01);
    chk(8'(err_count - e0), 8'h01);
    push(8'hee);
    chk(count, 8'h80);
    cpu.rd(8'hd9, d); chk(d, 8'h01);
    chk(count, 8'h7f);
    @(negedge sys_clk) rx_fl = 1'b1;
    @(negedge sys_clk) rx_fl = 1'b0;
    @(negedge sys_clk);
    chk(count, 8'h00);
    chk({nonempty, thresh}, 8'h00);
    push(8'h3c);
    @(negedge sys_clk);
    chk(count, 8'h01);
    cpu.rd(8'hd9, d); chk(d, 8'h3c);
    cpu.wr(8'he9, 8'h00);
    $display("test overflow done");
  endtask
  task automatic t_flags();
    logic [7:0] sb[6] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h02};
    logic [7:0] fb[6] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02, 8'h01};
    int e0;
    for (int i = 0; i < 6; i++) begin
      cpu.wr(8'he9, 8'h00);
      @(negedge sys_clk) src = sb[i];
      @(negedge sys_clk) src = '0;
      cpu.rd(8'he9, d); chk(d, fb[i]);
      chk({7'h0, irq}, 8'h00);
    end
    cpu.wr(8'he9, 8'h00);
    for (int a = 0; a < 2; a++) begin
      ack_sel = a[0];
      @(negedge sys_clk) src = 8'h20;
      @(negedge sys_clk) src = '0;
      cpu.rd(8'he9, d); chk(d, a == 0 ? 8'h00 : 8'h40);
    end
    cpu.wr(8'h91, 8'h48);
    cpu.rd(8'h91, d); chk(d, 8'h48);
    chk({7'h0, irq}, 8'h01);
    cpu.wr(8'he9, 8'hbf);
    cpu.rd(8'he9, d); chk(d, 8'h00);
    chk({7'h0, irq}, 8'h00);
    e0 = err_count;
    @(negedge sys_clk) src = 8'h01;
    @(negedge sys_clk) src = '0;
    repeat (2) @(negedge sys_clk);
    chk(8'(err_count - e0), 8'h01);
    chk({7'h0, irq}, 8'h00);
    $display("test flags done");
  endtask
  task automatic t_filter();
    filt = 1'b1;
    rxp('{delim_done: 1'b1, default: 1'b0});
    for (int i = 0; i < 5; i++)
      push(8'h60 + i[7:0]);
    @(negedge sys_clk);
    chk(count, 8'h05);
    chk({nonempty, thresh}, 8'h02);
    rxp('{addr_pass: 1'b1, default: 1'b0});
    @(negedge sys_clk);
    chk({delim, thresh}, 8'h03);
    rxp('{frame_end: 1'b1, default: 1'b0});
    chk({7'h0, delim}, 8'h00);
    cpu.rd(8'hd9, d); chk(d, 8'h60);
    @(negedge sys_clk) rx_fl = 1'b1;
    @(negedge sys_clk) rx_fl = 1'b0;
    rxp('{delim_done: 1'b1, default: 1'b0});
    push(8'h07);
    chk({7'h0, delim}, 8'h01);
    rxp('{addr_fail: 1'b1, default: 1'b0});
    chk({delim, thresh}, 8'h00);
    @(negedge sys_clk) rx_fl = 1'b1;
    @(negedge sys_clk) rx_fl = 1'b0;
    filt = 1'b0;
    cpu.wr(8'he9, 8'h00);
    $display("test filter done");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_tx();
    t_rx();
    t_short();
    t_over();
    t_flags();
    t_filter();
    summarize();
  end
endmodule
